// >>> core/msc_machine_state.sv
// Machine state word, its side effects, and the interrupt take or halt decision
//
// What this block does
// - Seven mask bits each mask bus return codes one to seven on data accesses.
// - Return code zero means success, never errors, but is still accumulated on data accesses.
// - Unmasked nonzero code on a data access raises a data machine check.
// - Masked nonzero code raises no exception.
// - Last-code field holds the code of the latest completed data access or failed fetch.
// - Nonzero code on an instruction fetch always raises an instruction check.
// - Fetches update the last-code field only when they fail.
// - In imprecise mode the last code is the last access to complete.
// - Taking an interrupt clears every field except last-code, which is exported, and a same-cycle completion's accumulator bit.
// - Four context bits drive the environment and do nothing inside.
// - Priority output is high when low-priority is clear or an event pends.
// - Wait-enable set and not halted means no fetch, wait state.
// - Any enabled asynchronous interrupt ends the wait state.
// - Unmaskable-enable set: controlled interrupts are taken normally.
// - Unmaskable-enable clear, check enabled: controlled interrupt taken as machine check.
// - Both enables clear: controlled interrupt halts as if taken.
// - External-enable set permits external and timer interrupts.
// - Check-enable clear: machine check halts as if taken.
// - Check-enable set: machine check taken first, cause valid at entry.
// - Wait-enable and low-priority bits are exported as status.
// - Accumulator bit per data or failed-fetch code; loaded by a word write, cleared by any interrupt or halt, a same-cycle completion still ORed in.
// - Imprecise-enable bit selects precise or imprecise error reporting.
`timescale 1ns/1ps
`default_nettype none
`include "msc_consts.svh"
module msc_machine_state (
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               mswWrEn,
  input  wire logic [31:0]        mswWrData,
  input  wire logic               busDone,
  input  wire logic [2:0]         busCode,
  input  wire logic               busIsFetch,
  input  wire logic               busIsStore,
  input  wire logic               extIrq,
  input  wire logic [2:0]         timerPend,
  input  wire logic               ctrlPend,
  input  wire msc_pkg::msc_ctrl_t ctrlKind,
  input  wire logic               resumeReq,
  output logic [31:0]             machineStateWord,
  output logic [2:0]              lastBusReturnCode,
  output logic [3:0]              contextBits,
  output logic                    lowPriorityRequest,
  output logic                    priorityOut,
  output logic                    waitStateOut,
  output logic                    haltedStatus,
  output logic                    impreciseEnable,
  output logic                    maskableEventPending,
  output logic                    irqTake,
  output msc_pkg::msc_take_t      irqKind,
  output logic [2:0]              checkCauseField
);
  import msc_pkg::*;

  logic [31:0] msw_r;
  logic [31:0] msw_nxt;
  logic        halted_r;
  logic        halted_nxt;
  logic        take_r;
  logic        take_nxt;
  msc_take_t   kind_r;
  msc_take_t   kind_nxt;
  logic [2:0]  cause_r;
  logic [2:0]  cause_nxt;
  logic        prio_r;
  logic        prio_nxt;
  logic        wait_r;
  logic        wait_nxt;
  logic        pend_r;
  logic        evtPend;
  logic        arbTake;
  logic        arbHalt;
  msc_take_t   arbKind;
  logic [2:0]  arbCause;
  logic        arbCauseValid;

  msc_event_if evIf ();

  msc_check_unit u_check (
    .busDone    (busDone),
    .busCode    (busCode),
    .busIsFetch (busIsFetch),
    .busIsStore (busIsStore),
    .imprecise_enable        (msw_r[`MSC_IPE]),
    .semBits    (msw_r[`MSC_SEMW_HI:`MSC_SEM_LO]),
    .ev         (evIf.source)
  );

  msc_arbiter u_arb (
    .ev         (evIf.sink),
    .halted     (halted_r),
    .ee         (msw_r[`MSC_EE]),
    .me         (msw_r[`MSC_ME]),
    .unmaskable_gate        (msw_r[`MSC_UIE]),
    .evtPend    (evtPend),
    .ctrlPend   (ctrlPend),
    .ctrlKind   (ctrlKind),
    .take       (arbTake),
    .halt       (arbHalt),
    .kind       (arbKind),
    .cause      (arbCause),
    .causeValid (arbCauseValid)
  );

  // Not gated by external-enable, only by the event sources themselves
  assign evtPend = extIrq || (|timerPend);

  always_comb begin
    msw_nxt    = msw_r;
    halted_nxt = halted_r;
    take_nxt   = 1'b0;
    kind_nxt   = MSC_TAKE_NONE;
    cause_nxt  = cause_r;
    if (halted_r && resumeReq) begin
      halted_nxt = 1'b0;
    end
    if (arbTake || arbHalt) begin
      // Halting leaves the same state as taking, minus the vector fetch
      msw_nxt    = msw_r & `MSC_KEEP_ON_TAKE;
      take_nxt   = arbTake;
      kind_nxt   = arbKind;
      halted_nxt = arbHalt || halted_nxt;
      if (arbCauseValid) begin
        cause_nxt = arbCause;
      end
    end else if (mswWrEn) begin
      msw_nxt = mswWrData & `MSC_MSW_WRMASK;
    end
    // Bus completion applied last so a same-cycle clear never loses it
    if (evIf.codeUpd) begin
      msw_nxt[`MSC_RC_HI:`MSC_RC_LO] = evIf.code;
    end
    msw_nxt[`MSC_ACC_HI:`MSC_ACC_LO] = msw_nxt[`MSC_ACC_HI:`MSC_ACC_LO] | evIf.accSet;
    prio_nxt = !msw_nxt[`MSC_LP] || evtPend;
    wait_nxt = msw_nxt[`MSC_WE] && !halted_nxt;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      msw_r    <= `MSC_MSW_RESET;
      halted_r <= 1'b0;
      take_r   <= 1'b0;
      kind_r   <= MSC_TAKE_NONE;
      cause_r  <= `MSC_MCS_IFETCH;
      prio_r   <= 1'b1;
      wait_r   <= 1'b0;
      pend_r   <= 1'b0;
    end else begin
      msw_r    <= msw_nxt;
      halted_r <= halted_nxt;
      take_r   <= take_nxt;
      kind_r   <= kind_nxt;
      cause_r  <= cause_nxt;
      prio_r   <= prio_nxt;
      wait_r   <= wait_nxt;
      pend_r   <= evtPend;
    end
  end

  assign machineStateWord     = msw_r;
  assign lastBusReturnCode    = msw_r[`MSC_RC_HI:`MSC_RC_LO];
  // Context bits only leave the block; nothing inside reads them
  assign contextBits          = {msw_r[`MSC_CTX0], msw_r[`MSC_CTX1],
                                 msw_r[`MSC_CTX2], msw_r[`MSC_CTX3]};
  assign lowPriorityRequest   = msw_r[`MSC_LP];
  assign priorityOut          = prio_r;
  assign waitStateOut         = wait_r;
  assign haltedStatus         = halted_r;
  assign impreciseEnable      = msw_r[`MSC_IPE];
  assign maskableEventPending = pend_r;
  assign irqTake              = take_r;
  assign irqKind              = kind_r;
  assign checkCauseField      = cause_r;

  // Checks

  logic semHit;
  assign semHit = |(msw_r[`MSC_SEMW_HI:`MSC_SEM_LO] & (`MSC_CODE_ONEHOT0 >> busCode));

  sequence s_dataFault;
    busDone && !busIsFetch && busCode != `MSC_RC_OK && !semHit && !halted_r;
  endsequence

  sequence s_checkTaken;
    take_r && kind_r == MSC_TAKE_MCHK;
  endsequence

  property p_accum_set;
    @(posedge clk) disable iff (reset)
    busDone && !busIsFetch |=> msw_r[`MSC_ACC_HI - $past(busCode)];
  endproperty
  a_accum_set: assert property (p_accum_set) else $error("accumulator bit not set");

  property p_code_capture;
    @(posedge clk) disable iff (reset)
    busDone && !busIsFetch |=> lastBusReturnCode == $past(busCode);
  endproperty
  a_code_capture: assert property (p_code_capture) else $error("last code not captured");

  property p_fetch_ok_quiet;
    @(posedge clk) disable iff (reset)
    busDone && busIsFetch && busCode == `MSC_RC_OK && !mswWrEn |=> $stable(lastBusReturnCode);
  endproperty
  a_fetch_ok_quiet: assert property (p_fetch_ok_quiet) else $error("good fetch changed last code");

  property p_unmasked_check;
    @(posedge clk) disable iff (reset)
    s_dataFault and msw_r[`MSC_ME] |=> s_checkTaken ##0 checkCauseField != `MSC_MCS_IFETCH;
  endproperty
  a_unmasked_check: assert property (p_unmasked_check) else $error("unmasked code not checked");

  property p_masked_quiet;
    @(posedge clk) disable iff (reset)
    busDone && !busIsFetch && semHit && !halted_r && !ctrlPend && !(evtPend && msw_r[`MSC_EE])
      |=> !irqTake && !haltedStatus;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("masked code raised exception");

  property p_fetch_check;
    @(posedge clk) disable iff (reset)
    busDone && busIsFetch && busCode != `MSC_RC_OK && msw_r[`MSC_ME] && !halted_r
      |=> s_checkTaken ##0 checkCauseField == `MSC_MCS_IFETCH;
  endproperty
  a_fetch_check: assert property (p_fetch_check) else $error("fetch failure not checked");

  property p_take_clears;
    @(posedge clk) disable iff (reset)
    irqTake |-> (msw_r & ~(`MSC_KEEP_ON_TAKE | `MSC_ACC_MASK)) == 32'h0000_0000;
  endproperty
  a_take_clears: assert property (p_take_clears) else $error("take left fields set");

  property p_priority;
    @(posedge clk) disable iff (reset)
    1'b1 |=> priorityOut == (!msw_r[`MSC_LP] || $past(evtPend));
  endproperty
  a_priority: assert property (p_priority) else $error("priority output wrong");

  property p_wait_state;
    @(posedge clk) disable iff (reset)
    waitStateOut == (msw_r[`MSC_WE] && !haltedStatus);
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("wait state output wrong");

  property p_check_halt;
    @(posedge clk) disable iff (reset)
    evIf.mchk && !msw_r[`MSC_ME] && !halted_r |=> haltedStatus && !irqTake ##1 haltedStatus || $past(resumeReq);
  endproperty
  a_check_halt: assert property (p_check_halt) else $error("check did not halt");

  property p_promoted;
    @(posedge clk) disable iff (reset)
    ctrlPend && !evIf.mchk && !msw_r[`MSC_UIE] && msw_r[`MSC_ME] && !halted_r
      |=> s_checkTaken ##0 checkCauseField == {`MSC_MCS_PROMOTED, $past(ctrlKind)};
  endproperty
  a_promoted: assert property (p_promoted) else $error("controlled interrupt not promoted");

  property p_ctrl_halt;
    @(posedge clk) disable iff (reset)
    ctrlPend && !evIf.mchk && !msw_r[`MSC_UIE] && !msw_r[`MSC_ME] && !halted_r |=> haltedStatus && !irqTake;
  endproperty
  a_ctrl_halt: assert property (p_ctrl_halt) else $error("controlled interrupt did not halt");

  property p_ctrl_normal;
    @(posedge clk) disable iff (reset)
    ctrlPend && !evIf.mchk && msw_r[`MSC_UIE] && !halted_r |=> irqTake && irqKind == MSC_TAKE_CTRL;
  endproperty
  a_ctrl_normal: assert property (p_ctrl_normal) else $error("controlled interrupt not taken");

  property p_ext_take;
    @(posedge clk) disable iff (reset)
    evtPend && msw_r[`MSC_EE] && !ctrlPend && !evIf.mchk && !halted_r
      |=> irqTake && irqKind == MSC_TAKE_EXT && !waitStateOut;
  endproperty
  a_ext_take: assert property (p_ext_take) else $error("async interrupt not taken");

  property p_reserved_zero;
    @(posedge clk) disable iff (reset)
    (msw_r & ~`MSC_MSW_WRMASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_context;
    @(posedge clk) disable iff (reset)
    mswWrEn && !arbTake && !arbHalt |=> contextBits == {$past(mswWrData[`MSC_CTX0]), $past(mswWrData[`MSC_CTX1]),
                                                      $past(mswWrData[`MSC_CTX2]), $past(mswWrData[`MSC_CTX3])};
  endproperty
  a_context: assert property (p_context) else $error("context bits not driven");

  property p_imprecise_cause;
    @(posedge clk) disable iff (reset)
    s_dataFault and busIsStore && msw_r[`MSC_IPE] && msw_r[`MSC_ME] |=> checkCauseField == `MSC_MCS_ISTORE;
  endproperty
  a_imprecise_cause: assert property (p_imprecise_cause) else $error("imprecise store cause wrong");
endmodule
`default_nettype wire

// >>> core/msc_consts.svh
// Bit positions, masks, reset values and cause codes of the machine state control block
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// Word bits in little-endian index order (index 31 is the leftmost bit)
`define MSC_MSW_RESET     32'h0000_0000
`define MSC_MSW_WRMASK    32'h7fff_9dff
`define MSC_KEEP_ON_TAKE  32'h0070_0000
`define MSC_ACC_MASK      32'h0000_00ff
`define MSC_SEM_HI        30
`define MSC_SEM_LO        24
`define MSC_SEMW_HI       31
`define MSC_CTX0          23
`define MSC_RC_HI         22
`define MSC_RC_LO         20
`define MSC_LP            19
`define MSC_WE            18
`define MSC_CTX1          17
`define MSC_UIE           16
`define MSC_EE            15
`define MSC_ME            12
`define MSC_CTX2          11
`define MSC_CTX3          10
`define MSC_IPE           8
`define MSC_ACC_HI        7
`define MSC_ACC_LO        0

// Check cause codes
`define MSC_MCS_IFETCH    3'h0
`define MSC_MCS_LOAD      3'h1
`define MSC_MCS_PSTORE    3'h2
`define MSC_MCS_ISTORE    3'h3
`define MSC_MCS_PROMOTED  1'h1
`define MSC_RC_OK         3'h0
`define MSC_CODE_ONEHOT0  8'h80

`endif

// >>> core/msc_pkg.sv
// Types shared by the machine state control modules
package msc_pkg;
  typedef enum logic [1:0] {
    MSC_TAKE_NONE = 2'b00,
    MSC_TAKE_MCHK = 2'b01,
    MSC_TAKE_CTRL = 2'b10,
    MSC_TAKE_EXT  = 2'b11
  } msc_take_t;

  typedef enum logic [1:0] {
    MSC_CTRL_PROG  = 2'b00,
    MSC_CTRL_ISI   = 2'b01,
    MSC_CTRL_ALIGN = 2'b10,
    MSC_CTRL_DSI   = 2'b11
  } msc_ctrl_t;
endpackage

// >>> core/msc_event_if.sv
// Carrier of service bus completion results between checker, arbiter and top
`timescale 1ns/1ps
`default_nettype none
interface msc_event_if;
  logic       mchk;
  logic [2:0] cause;
  logic       codeUpd;
  logic [2:0] code;
  logic [7:0] accSet;

  modport source (output mchk, output cause, output codeUpd, output code, output accSet);
  modport sink   (input mchk, input cause, input codeUpd, input code, input accSet);
endinterface
`default_nettype wire

// >>> core/msc_check_unit.sv
// Evaluates service bus return codes against the error mask
`timescale 1ns/1ps
`default_nettype none
`include "msc_consts.svh"
module msc_check_unit (
  input  wire logic       busDone,
  input  wire logic [2:0] busCode,
  input  wire logic       busIsFetch,
  input  wire logic       busIsStore,
  input  wire logic       imprecise_enable,
  input  wire logic [7:0] semBits,
  msc_event_if.source     ev
);
  import msc_pkg::*;

  logic nonzero;
  logic masked;

  function automatic logic [7:0] codeOneHot(input logic [2:0] c);
    return `MSC_CODE_ONEHOT0 >> c;
  endfunction

  always_comb begin
    nonzero    = busCode != `MSC_RC_OK;
    // Top bit of semBits is the reserved bit, never set, so code 0 is never masked
    masked     = |(semBits & codeOneHot(busCode));
    // Fetches only record on failure
    ev.codeUpd = busDone && (!busIsFetch || nonzero);
    ev.code    = busCode;
    ev.accSet  = ev.codeUpd ? codeOneHot(busCode) : 8'h00;
    ev.mchk    = busDone && nonzero && (busIsFetch || !masked);
    if (busIsFetch) begin
      ev.cause = `MSC_MCS_IFETCH;
    end else if (!busIsStore) begin
      ev.cause = `MSC_MCS_LOAD;
    end else if (imprecise_enable) begin
      ev.cause = `MSC_MCS_ISTORE;
    end else begin
      ev.cause = `MSC_MCS_PSTORE;
    end
  end
endmodule
`default_nettype wire

// >>> core/msc_arbiter.sv
// Decides between taking an interrupt, halting, or nothing
`timescale 1ns/1ps
`default_nettype none
`include "msc_consts.svh"
module msc_arbiter (
  msc_event_if.sink            ev,
  input  wire logic            halted,
  input  wire logic            ee,
  input  wire logic            me,
  input  wire logic            unmaskable_gate,
  input  wire logic            evtPend,
  input  wire logic            ctrlPend,
  input  wire msc_pkg::msc_ctrl_t ctrlKind,
  output logic                 take,
  output logic                 halt,
  output msc_pkg::msc_take_t   kind,
  output logic [2:0]           cause,
  output logic                 causeValid
);
  import msc_pkg::*;

  always_comb begin
    take       = 1'b0;
    halt       = 1'b0;
    kind       = MSC_TAKE_NONE;
    cause      = ev.cause;
    causeValid = 1'b0;
    if (!halted) begin
      if (ev.mchk) begin
        causeValid = 1'b1;
        take       = me;
        halt       = !me;
        kind       = me ? MSC_TAKE_MCHK : MSC_TAKE_NONE;
      end else if (ctrlPend) begin
        if (unmaskable_gate) begin
          take = 1'b1;
          kind = MSC_TAKE_CTRL;
        end else begin
          cause      = {`MSC_MCS_PROMOTED, ctrlKind};
          causeValid = 1'b1;
          take       = me;
          halt       = !me;
          kind       = me ? MSC_TAKE_MCHK : MSC_TAKE_NONE;
        end
      end else if (ee && evtPend) begin
        // Async interrupt also ends the wait state
        take = 1'b1;
        kind = MSC_TAKE_EXT;
      end
    end
  end
endmodule
`default_nettype wire

// >>> dv/msc_env_model.sv
// Environment and service bus model facing the machine state control block
`timescale 1ns/1ps
`default_nettype none
module msc_env_model (
  input  wire logic               clk,
  output logic                    busDone,
  output logic [2:0]              busCode,
  output logic                    busIsFetch,
  output logic                    busIsStore,
  output logic                    extIrq,
  output logic [2:0]              timerPend,
  output logic                    ctrlPend,
  output msc_pkg::msc_ctrl_t      ctrlKind,
  output logic                    resumeReq
);
  import msc_pkg::*;

  initial begin
    busDone    = 1'b0;
    busCode    = 3'h5;
    busIsFetch = 1'b1;
    busIsStore = 1'b1;
    extIrq     = 1'b0;
    timerPend  = 3'h0;
    ctrlPend   = 1'b0;
    ctrlKind   = MSC_CTRL_DSI;
    resumeReq  = 1'b0;
  end

  // Qualifiers go inverse when idle, so a stale code never looks valid
  task automatic busAccess(input logic [2:0] code, input logic fetch, input logic store);
    @(posedge clk);
    busDone    <= 1'b1;
    busCode    <= code;
    busIsFetch <= fetch;
    busIsStore <= store;
    @(posedge clk);
    busDone    <= 1'b0;
    busCode    <= ~code;
    busIsFetch <= ~fetch;
    busIsStore <= ~store;
  endtask

  // Levels are dropped hold clock edges later, right after the take when hold is 1, as the core would do
  task automatic raise(input logic ext, input logic [2:0] tmr, input logic ctl, input msc_ctrl_t kind,
                       input int unsigned hold);
    @(posedge clk);
    extIrq    <= ext;
    timerPend <= tmr;
    ctrlPend  <= ctl;
    ctrlKind  <= kind;
    repeat (hold) @(posedge clk);
    extIrq    <= 1'b0;
    timerPend <= 3'h0;
    ctrlPend  <= 1'b0;
    ctrlKind  <= msc_ctrl_t'(~kind);
  endtask

  task automatic resume();
    @(posedge clk);
    resumeReq <= 1'b1;
    @(posedge clk);
    resumeReq <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench of the machine state control block
`timescale 1ns/1ps
`default_nettype none
`include "msc_consts.svh"
module testbench;
  import msc_pkg::*;
  localparam logic [31:0] meBit  = 32'h1 << `MSC_ME;
  localparam logic [31:0] uieBit = 32'h1 << `MSC_UIE;
  localparam logic [31:0] eeBit  = 32'h1 << `MSC_EE;
  localparam logic [31:0] weBit  = 32'h1 << `MSC_WE;
  localparam logic [31:0] lpBit  = 32'h1 << `MSC_LP;
  localparam logic [31:0] ipeBit = 32'h1 << `MSC_IPE;
  localparam logic [31:0] semAll = 32'h7f << `MSC_SEM_LO;
  logic        clk;
  logic        reset;
  logic        mswWrEn;
  logic [31:0] mswWrData;
  logic        busDone;
  logic [2:0]  busCode;
  logic        busIsFetch;
  logic        busIsStore;
  logic        extIrq;
  logic [2:0]  timerPend;
  logic        ctrlPend;
  msc_ctrl_t   ctrlKind;
  logic        resumeReq;
  logic [31:0] machineStateWord;
  logic [2:0]  lastBusReturnCode;
  logic [3:0]  contextBits;
  logic        lowPriorityRequest;
  logic        priorityOut;
  logic        waitStateOut;
  logic        haltedStatus;
  logic        impreciseEnable;
  logic        maskableEventPending;
  logic        irqTake;
  msc_take_t   irqKind;
  logic [2:0]  checkCauseField;
  logic [31:0] expW;
  int          errorCnt;
  int          cmpCount;

  always #2.5 clk = ~clk;

  msc_env_model env (.clk(clk), .busDone(busDone), .busCode(busCode), .busIsFetch(busIsFetch),
    .busIsStore(busIsStore), .extIrq(extIrq), .timerPend(timerPend), .ctrlPend(ctrlPend),
    .ctrlKind(ctrlKind), .resumeReq(resumeReq));

  msc_machine_state uut (.clk(clk), .reset(reset), .mswWrEn(mswWrEn), .mswWrData(mswWrData),
    .busDone(busDone), .busCode(busCode), .busIsFetch(busIsFetch), .busIsStore(busIsStore),
    .extIrq(extIrq), .timerPend(timerPend), .ctrlPend(ctrlPend), .ctrlKind(ctrlKind),
    .resumeReq(resumeReq), .machineStateWord(machineStateWord), .lastBusReturnCode(lastBusReturnCode),
    .contextBits(contextBits), .lowPriorityRequest(lowPriorityRequest), .priorityOut(priorityOut),
    .waitStateOut(waitStateOut), .haltedStatus(haltedStatus), .impreciseEnable(impreciseEnable),
    .maskableEventPending(maskableEventPending), .irqTake(irqTake), .irqKind(irqKind),
    .checkCauseField(checkCauseField));

  function automatic logic [31:0] rcw(input int c);
    return (32'(c) << `MSC_RC_LO) | (32'h1 << (7 - c));
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wrWord(input logic [31:0] d);
    @(posedge clk);
    mswWrEn   <= 1'b1;
    mswWrData <= d;
    @(posedge clk);
    mswWrEn   <= 1'b0;
    mswWrData <= ~d;
    #1;
    expW = d & `MSC_MSW_WRMASK;
    chk(machineStateWord, expW, "word write");
  endtask

  // Cause is only checked here on a machine check take
  task automatic takeChk(input logic tk, input msc_take_t k, input logic [2:0] cs, input logic [31:0] w);
    chk(32'(irqTake), 32'(tk), "take");
    chk(32'(irqKind), 32'(k), "kind");
    if (k == MSC_TAKE_MCHK) chk(32'(checkCauseField), 32'(cs), "cause");
    chk(machineStateWord, w, "word after event");
  endtask

  task automatic testDone(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    $display("BAD %0t run limit reached", $time);
    errorCnt++;
    end_of_test();
  end

  initial begin
    int c;
    int k;
    int ctxPos [4];
    logic [31:0] w;
    ctxPos = '{`MSC_CTX0, `MSC_CTX1, `MSC_CTX2, `MSC_CTX3};
    clk = 1'b0;
    reset = 1'b1;
    mswWrEn = 1'b0;
    mswWrData = 32'h0;
    errorCnt = 0;
    cmpCount = 0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(machineStateWord, `MSC_MSW_RESET, "reset word");
    chk(32'({priorityOut, waitStateOut, haltedStatus}), 32'h4, "reset status");
    testDone("reset");
    wrWord(32'hffff_ffff);
    chk(32'(contextBits), 32'hf, "context");
    chk(32'({lowPriorityRequest, waitStateOut, impreciseEnable}), 32'h7, "status");
    chk(32'(lastBusReturnCode), 32'h7, "code view");
    chk(32'(priorityOut), 32'h0, "priority idle");
    for (k = 0; k < 4; k++) begin
      wrWord(32'h1 << ctxPos[k]);
      chk(32'(contextBits), 32'h8 >> k, "context walk");
    end
    testDone("fields");
    for (c = 0; c < 8; c++) begin
      wrWord(meBit);
      env.busAccess(3'(c), 1'b0, 1'b0);
      #1;
      if (c == 0) takeChk(1'b0, MSC_TAKE_NONE, 3'h0, meBit | rcw(0));
      else takeChk(1'b1, MSC_TAKE_MCHK, `MSC_MCS_LOAD, rcw(c));
    end
    for (c = 1; c < 8; c++) begin
      w = meBit | (32'h1 << (31 - c));
      wrWord(w);
      env.busAccess(3'(c), 1'b0, 1'b0);
      #1;
      takeChk(1'b0, MSC_TAKE_NONE, 3'h0, w | rcw(c));
      env.busAccess(3'(c % 7 + 1), 1'b0, 1'b0);
      #1;
      takeChk(1'b1, MSC_TAKE_MCHK, `MSC_MCS_LOAD, rcw(c % 7 + 1));
    end
    wrWord(meBit | semAll);
    env.busAccess(3'h1, 1'b0, 1'b0);
    env.busAccess(3'h2, 1'b0, 1'b0);
    #1;
    chk(machineStateWord, expW | 32'h0000_0060 | (32'h2 << `MSC_RC_LO), "accumulate");
    wrWord(meBit);
    env.busAccess(3'h4, 1'b0, 1'b1);
    #1;
    takeChk(1'b1, MSC_TAKE_MCHK, `MSC_MCS_PSTORE, rcw(4));
    wrWord(meBit | ipeBit);
    env.busAccess(3'h4, 1'b0, 1'b1);
    #1;
    takeChk(1'b1, MSC_TAKE_MCHK, `MSC_MCS_ISTORE, rcw(4));
    testDone("data access");
    wrWord(meBit | semAll);
    env.busAccess(3'h0, 1'b1, 1'b0);
    #1;
    takeChk(1'b0, MSC_TAKE_NONE, 3'h0, expW);
    env.busAccess(3'h5, 1'b1, 1'b0);
    #1;
    takeChk(1'b1, MSC_TAKE_MCHK, `MSC_MCS_IFETCH, rcw(5));
    testDone("fetch");
    wrWord(32'h0);
    env.busAccess(3'h3, 1'b0, 1'b0);
    #1;
    takeChk(1'b0, MSC_TAKE_NONE, 3'h0, rcw(3));
    chk(32'({haltedStatus, checkCauseField}), 32'h9, "halt on check");
    wrWord(weBit);
    chk(32'(waitStateOut), 32'h0, "no wait while halted");
    env.resume();
    @(posedge clk);
    #1;
    chk(32'({haltedStatus, waitStateOut}), 32'h1, "resumed");
    testDone("check halt");
    for (k = 0; k < 4; k++) begin
      wrWord(uieBit | meBit);
      env.raise(1'b0, 3'h0, 1'b1, msc_ctrl_t'(k), 1);
      #1;
      takeChk(1'b1, MSC_TAKE_CTRL, 3'h0, 32'h0);
      wrWord(meBit);
      env.raise(1'b0, 3'h0, 1'b1, msc_ctrl_t'(k), 1);
      #1;
      takeChk(1'b1, MSC_TAKE_MCHK, {`MSC_MCS_PROMOTED, 2'(k)}, 32'h0);
      wrWord(32'h0);
      env.raise(1'b0, 3'h0, 1'b1, msc_ctrl_t'(k), 1);
      #1;
      takeChk(1'b0, MSC_TAKE_NONE, 3'h0, 32'h0);
      chk(32'(haltedStatus), 32'h1, "halt on ctrl");
      env.resume();
    end
    testDone("controlled");
    for (k = 0; k < 4; k++) begin
      wrWord(eeBit | weBit);
      chk(32'(waitStateOut), 32'h1, "waiting");
      env.raise(k == 3, (k < 3) ? 3'(1 << k) : 3'h0, 1'b0, MSC_CTRL_PROG, 1);
      #1;
      takeChk(1'b1, MSC_TAKE_EXT, 3'h0, 32'h0);
      chk(32'(waitStateOut), 32'h0, "wait left");
    end
    wrWord(lpBit);
    env.raise(1'b1, 3'h0, 1'b0, MSC_CTRL_PROG, 3);
    #1;
    chk(machineStateWord, lpBit, "event held off");
    chk(32'({maskableEventPending, priorityOut}), 32'h3, "event pending");
    repeat (3) @(posedge clk);
    #1;
    chk(32'({maskableEventPending, priorityOut}), 32'h0, "event gone");
    testDone("external");
    end_of_test();
  end
endmodule
`default_nettype wire
